// *** logic/pwm_channel.sv ***
// One PWM output channel: local or shifted counter with pulse compare
`timescale 1ns/100ps
`default_nettype none
module pwm_channel
	import pwm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic local_tb,
	input wire logic [15:0] period,
	input wire logic [15:0] phase,
	input wire logic [15:0] duty,
	input wire logic [15:0] master_cnt,
	output logic out_q,
	output logic wrap_q
);
	typedef struct packed {
		logic [15:0] cnt;
		logic out;
		logic wrap;
	} ch_state_t;
	ch_state_t s_q, s_d;
	logic [15:0] pos;
	logic [15:0] edge_duty;

	// Shifted position against the master count, or own local counter
	always_comb begin
		s_d = s_q;
		s_d.wrap = 1'b0;
		if (!run) begin
			s_d.cnt = RST_VAL;
			s_d.out = 1'b0;
		end else if (local_tb) begin
			if (s_q.cnt >= period) begin
				s_d.cnt = RST_VAL;
				s_d.wrap = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
		end else begin
			s_d.cnt = master_cnt;
			s_d.wrap = (master_cnt == phase);
		end
		pos = local_tb ? s_d.cnt : (s_d.cnt - phase);
		// Coarser step near the ends: low bits dropped inside the edge band
		edge_duty = duty;
		if (duty < 16'(EDGE_BAND_CYC) || duty > period - 16'(EDGE_BAND_CYC)) begin
			edge_duty = {duty[15:2], 2'b00};
		end
		s_d.out = run && (pos < edge_duty);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign out_q = s_q.out;
	assign wrap_q = s_q.wrap;
endmodule
`default_nettype wire

// *** logic/pwm_phase_deadtime_trigger.sv ***
// Top: AXI4-Lite register file, two PWM channels, trigger divider
//
// Overview of operation
// - Secondary duty drives low side only independently
// - Duty step coarsens near zero or full
// - Master base, paired modes: phase shifts both
// - Master base, independent: phase shifts high only
// - Local base, paired modes: phase is period
// - Local base, independent: phase is high period
// - Secondary phase ignored in paired modes
// - Independent, master base: secondary shifts low
// - Independent, local base: secondary is low period
// - Dead time fourteen bits, top bits zero
// - Alternate dead time likewise fourteen bits
// - Trigger every divider-plus-one events
// - Local select picks own period, else master
// - Combine bit merges secondary into primary trigger
// - Start field delays first trigger cycles
`timescale 1ns/100ps
`default_nettype none
module pwm_phase_deadtime_trigger
	import pwm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic high_side_output,
	output logic low_side_output,
	output logic [13:0] active_dead_time,
	output logic adc_trigger,
	output logic adc_trigger_secondary
);
	typedef struct packed {
		logic [15:0] secondary_duty_cycle;
		logic [15:0] primary_phase_or_period;
		logic [15:0] secondary_phase_or_period;
		logic [15:0] dead_time_value;
		logic [15:0] alternate_dead_time_value;
		logic [15:0] trigger_control;
		logic [15:0] generator_control;
		logic [15:0] primary_duty_cycle;
		logic [15:0] master_period;
		logic [15:0] master_cnt;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [5:0] start_cnt;
		logic [3:0] div_cnt;
		logic trig;
		logic trig2;
		logic [13:0] dt;
		logic hi;
		logic lo;
		logic run_d;
	} top_state_t;
	top_state_t s_q, s_d;

	logic run, local_tb, indep;
	logic [1:0] pin_mode;
	logic hi_ch, lo_ch, hi_wrap, lo_wrap;
	logic [15:0] lo_period, lo_phase, lo_duty, hi_period;
	logic [15:0] wval;
	logic [31:0] rd_word;
	logic rd_ok, wr_ok, do_wr, ev_pri, ev_sec, ev_any, ev_tick;

	assign run = s_q.generator_control[CTRL_EN];
	assign local_tb = s_q.generator_control[CTRL_ITB];
	assign pin_mode = s_q.generator_control[CTRL_PM_HI:CTRL_PM_LO];
	assign indep = (pin_mode == PM_INDEP);

	////////////////////////////////////////////////////////////////
	// Channel setup per pin mode and time-base select
	always_comb begin
		hi_period = local_tb ? s_q.primary_phase_or_period : s_q.master_period;
		if (indep) begin
			lo_period = local_tb ? s_q.secondary_phase_or_period : s_q.master_period;
			lo_phase = s_q.secondary_phase_or_period;
			lo_duty = s_q.secondary_duty_cycle;
		end else begin
			lo_period = hi_period;
			lo_phase = s_q.primary_phase_or_period;
			lo_duty = s_q.primary_duty_cycle;
		end
	end

	// High side uses primary phase alone in every mode
	pwm_channel u_high (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run),
		.local_tb(local_tb),
		.period(hi_period),
		.phase(s_q.primary_phase_or_period),
		.duty(s_q.primary_duty_cycle),
		.master_cnt(s_q.master_cnt),
		.out_q(hi_ch),
		.wrap_q(hi_wrap)
	);

	pwm_channel u_low (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run),
		.local_tb(local_tb),
		.period(lo_period),
		.phase(lo_phase),
		.duty(lo_duty),
		.master_cnt(s_q.master_cnt),
		.out_q(lo_ch),
		.wrap_q(lo_wrap)
	);

	////////////////////////////////////////////////////////////////
	// Read mux; unmapped offsets answer with an error
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			OFF_SDC: rd_word[15:0] = s_q.secondary_duty_cycle;
			OFF_PHASE: rd_word[15:0] = s_q.primary_phase_or_period;
			OFF_SPHASE: rd_word[15:0] = s_q.secondary_phase_or_period;
			OFF_DTR: rd_word[15:0] = s_q.dead_time_value & DT_MASK;
			OFF_ALTDTR: rd_word[15:0] = s_q.alternate_dead_time_value & DT_MASK;
			OFF_TRGCON: rd_word[15:0] = s_q.trigger_control & TRGCON_MASK;
			OFF_CTRL: rd_word[15:0] = s_q.generator_control & CTRL_MASK;
			OFF_PDC: rd_word[15:0] = s_q.primary_duty_cycle;
			OFF_MPER: rd_word[15:0] = s_q.master_period;
			OFF_STATUS: rd_word[15:0] = {s_q.start_cnt, 6'h00, s_q.div_cnt};
			default: rd_ok = 1'b0;
		endcase
	end

	// Write decode of the stored address
	always_comb begin
		wval = s_q.w_data[15:0];
		if (!s_q.w_strb[0]) begin
			wval[7:0] = 8'h00;
		end
		if (!s_q.w_strb[1]) begin
			wval[15:8] = 8'h00;
		end
		unique case (s_q.aw_addr)
			OFF_SDC, OFF_PHASE, OFF_SPHASE, OFF_DTR, OFF_ALTDTR, OFF_TRGCON, OFF_CTRL, OFF_PDC,
			OFF_MPER, OFF_STATUS: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
		do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	end

	////////////////////////////////////////////////////////////////
	// Trigger events: primary at high-side cycle start, secondary at low-side
	assign ev_pri = run && hi_wrap;
	assign ev_sec = run && indep && lo_wrap;
	assign ev_any = ev_pri || (s_q.trigger_control[DTM_BIT] && ev_sec);
	assign ev_tick = ev_pri || ev_sec;

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.trig = 1'b0;
		s_d.trig2 = 1'b0;
		// Bus channels: address and data taken in either order
		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (do_wr) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			// Byte lanes without a strobe are written as zero, not kept from the stored value
			unique case (s_q.aw_addr)
				OFF_SDC: s_d.secondary_duty_cycle = wval;
				OFF_PHASE: s_d.primary_phase_or_period = wval;
				OFF_SPHASE: s_d.secondary_phase_or_period = wval;
				OFF_DTR: s_d.dead_time_value = wval & DT_MASK;
				OFF_ALTDTR: s_d.alternate_dead_time_value = wval & DT_MASK;
				OFF_TRGCON: s_d.trigger_control = wval & TRGCON_MASK;
				OFF_CTRL: s_d.generator_control = wval & CTRL_MASK;
				OFF_PDC: s_d.primary_duty_cycle = wval;
				OFF_MPER: s_d.master_period = wval;
				default: ;
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word;
			s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Master time base
		if (!run || s_q.master_cnt >= s_q.master_period) begin
			s_d.master_cnt = RST_VAL;
		end else begin
			s_d.master_cnt = s_q.master_cnt + 16'h0001;
		end
		// Start delay counted in trigger events after enable: high-side cycle starts, plus low-side ones in independent mode
		s_d.run_d = run;
		if (run && !s_q.run_d) begin
			s_d.start_cnt = s_q.trigger_control[TSTRT_HI:0];
			s_d.div_cnt = 4'h0;
		end else if (!run) begin
			s_d.start_cnt = 6'h00;
			s_d.div_cnt = 4'h0;
		end else if (s_q.start_cnt != 6'h00) begin
			if (ev_tick) begin
				s_d.start_cnt = s_q.start_cnt - 6'h01;
			end
		end else if (ev_any) begin
			// Postscaler: fire then restart, every code+1 events
			if (s_q.div_cnt >= s_q.trigger_control[TDIV_HI:TDIV_LO]) begin
				s_d.div_cnt = 4'h0;
				s_d.trig = 1'b1;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 4'h1;
			end
		end
		// Separate secondary trigger when not combined
		if (run && s_q.start_cnt == 6'h00 && ev_sec && !s_q.trigger_control[DTM_BIT]) begin
			s_d.trig2 = 1'b1;
		end
		s_d.dt = s_q.generator_control[CTRL_ALT] ? s_q.alternate_dead_time_value[DT_W-1:0]
			: s_q.dead_time_value[DT_W-1:0];
		s_d.hi = hi_ch;
		s_d.lo = indep ? lo_ch : !hi_ch && run;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready = !s_q.w_got;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign high_side_output = s_q.hi;
	assign low_side_output = s_q.lo;
	assign active_dead_time = s_q.dt;
	assign adc_trigger = s_q.trig;
	assign adc_trigger_secondary = s_q.trig2;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	dt_top_zero_a: assert property (s_q.dead_time_value[15:14] == 2'b00)
		else $error("dead time top bits set");
	adt_top_zero_a: assert property (s_q.alternate_dead_time_value[15:14] == 2'b00)
		else $error("alt dead time top bits set");
	div_fire_a: assert property (s_q.start_cnt == 6'h00 && ev_any && run && s_q.run_d
		&& s_q.div_cnt == s_q.trigger_control[TDIV_HI:TDIV_LO] |=> adc_trigger)
		else $error("divider did not fire");
	div_hold_a: assert property (ev_any && s_q.div_cnt < s_q.trigger_control[TDIV_HI:TDIV_LO]
		|=> !adc_trigger)
		else $error("early trigger");
	start_wait_a: assert property (s_q.start_cnt != 6'h00 |=> !adc_trigger)
		else $error("trigger during start delay");
	sec_merge_a: assert property (s_q.trigger_control[DTM_BIT] |=> !adc_trigger_secondary)
		else $error("secondary trigger while combined");
	lo_pair_a: assert property (run && s_q.run_d && !indep && $stable(pin_mode)
		|=> low_side_output == (!$past(hi_ch) && $past(run)))
		else $error("low side not complementary");
	lo_period_a: assert property (!indep |-> lo_period == hi_period)
		else $error("secondary phase used in paired mode");
	hi_period_a: assert property (local_tb |-> hi_period == s_q.primary_phase_or_period)
		else $error("local period not taken");
	// Two register stages lie between enable and the pin, so a stop shows two cycles on
	idle_low_a: assert property (!run |-> ##2 !high_side_output)
		else $error("output while stopped");

	////////////////////////////////////////////////////////////////
	// Next-cycle checks, the first two built from named sequences
	sequence run_rise_s;
		run && !s_q.run_d;
	endsequence
	sequence sec_event_s;
		run && s_q.start_cnt == 6'h00 && ev_sec && !s_q.trigger_control[DTM_BIT];
	endsequence

	start_load_a: assert property (run_rise_s
		|=> s_q.start_cnt == $past(s_q.trigger_control[TSTRT_HI:0]))
		else $error("start delay not loaded");
	sec_sep_a: assert property (sec_event_s |=> adc_trigger_secondary)
		else $error("separate secondary trigger missing");
	lo_indep_a: assert property (indep |=> low_side_output == $past(lo_ch))
		else $error("low side not from secondary channel");
	dt_pick_a: assert property (!s_q.generator_control[CTRL_ALT]
		|=> active_dead_time == $past(s_q.dead_time_value[DT_W-1:0]))
		else $error("primary dead time not selected");
	adt_pick_a: assert property (s_q.generator_control[CTRL_ALT]
		|=> active_dead_time == $past(s_q.alternate_dead_time_value[DT_W-1:0]))
		else $error("alternate dead time not selected");
endmodule
`default_nettype wire

// *** logic/pwm_pkg.sv ***
// Package with register map, field layout and timing constants for the PWM generator
package pwm_pkg;
	localparam int DATA_W = 16;
	localparam int DT_W = 14;
	localparam logic [7:0] OFF_SDC = 8'h00;
	localparam logic [7:0] OFF_PHASE = 8'h04;
	localparam logic [7:0] OFF_SPHASE = 8'h08;
	localparam logic [7:0] OFF_DTR = 8'h0c;
	localparam logic [7:0] OFF_ALTDTR = 8'h10;
	localparam logic [7:0] OFF_TRGCON = 8'h14;
	localparam logic [7:0] OFF_CTRL = 8'h18;
	localparam logic [7:0] OFF_PDC = 8'h1c;
	localparam logic [7:0] OFF_MPER = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [15:0] RST_VAL = 16'h0000;
	localparam logic [15:0] DT_MASK = 16'h3fff;
	localparam logic [15:0] TRGCON_MASK = 16'hf0bf;
	localparam int TDIV_HI = 15;
	localparam int TDIV_LO = 12;
	localparam int DTM_BIT = 7;
	localparam int TSTRT_HI = 5;
	localparam int CTRL_EN = 0;
	localparam int CTRL_ITB = 1;
	localparam int CTRL_ALT = 2;
	localparam int CTRL_PM_LO = 4;
	localparam int CTRL_PM_HI = 5;
	localparam logic [15:0] CTRL_MASK = 16'h0037;
	localparam logic [1:0] PM_INDEP = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int EDGE_BAND_NS = 40;
	localparam int CLK_NS = 25;
	localparam int EDGE_BAND_CYC = (EDGE_BAND_NS / CLK_NS) < 1 ? 1 : (EDGE_BAND_NS / CLK_NS);
endpackage

// *** test/pwm_far_side.sv ***
// Far-side model: power stage legs and converter trigger input, tallying what arrives
`timescale 1ns/100ps
`default_nettype none
module pwm_far_side (
	input wire logic aclk,
	input wire logic high_side_output,
	input wire logic low_side_output,
	input wire logic adc_trigger,
	input wire logic adc_trigger_secondary,
	output var int hs_on,
	output var int ls_on,
	output var int hs_up,
	output var int ls_up,
	output var int trg,
	output var int trg2,
	output var int same
);
	logic hs_q = 1'b0;
	logic ls_q = 1'b0;

	////////////////////////////////////////////////////////////////
	// Running tallies; the bench differences them over whole periods
	always @(posedge aclk) begin
		hs_q <= high_side_output;
		ls_q <= low_side_output;
		hs_on <= hs_on + int'(high_side_output === 1'b1);
		ls_on <= ls_on + int'(low_side_output === 1'b1);
		hs_up <= hs_up + int'(high_side_output === 1'b1 && hs_q === 1'b0);
		ls_up <= ls_up + int'(low_side_output === 1'b1 && ls_q === 1'b0);
		trg <= trg + int'(adc_trigger === 1'b1);
		trg2 <= trg2 + int'(adc_trigger_secondary === 1'b1);
		// Equal legs in a paired mode would short the bridge
		same <= same + int'(high_side_output === low_side_output);
	end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench: register map, output timing per mode, trigger divider
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pwm_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, hs, ls, trg_o, trg2_o;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [13:0] adt;
	logic [15:0] v;
	logic [15:0] lfsr_q = 16'h001b;
	logic [15:0] msk [6] = '{16'hffff, 16'hffff, 16'hffff, 16'h3fff, 16'h3fff, 16'hf0bf};
	int mdl [6];
	int codes [4] = '{0, 1, 10, 15};
	int hs_on, ls_on, hs_up, ls_up, trg, trg2, same, g, g0;
	int err_total = 0;
	int cmp_count = 0;

	always #12.5 aclk = ~aclk;

	pwm_phase_deadtime_trigger u_pwm_phase_deadtime_trigger (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .high_side_output(hs), .low_side_output(ls), .active_dead_time(adt),
		.adc_trigger(trg_o), .adc_trigger_secondary(trg2_o));
	pwm_far_side u_pwm_far_side (.aclk(aclk), .high_side_output(hs), .low_side_output(ls),
		.adc_trigger(trg_o), .adc_trigger_secondary(trg2_o), .hs_on(hs_on), .ls_on(ls_on),
		.hs_up(hs_up), .ls_up(ls_up), .trg(trg), .trg2(trg2), .same(same));

	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Write; bready stays high, upper data lanes carry noise that must be ignored
	task automatic wr(input logic [7:0] a, input logic [15:0] x, output logic [1:0] rs);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		lfsr_q = lfsr_next(lfsr_q);
		awaddr <= a;
		wdata <= {lfsr_q, x};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		x = rdata;
		rs = rresp;
	endtask

	// Restart the generator with new phase, trigger and control, then let it settle
	task automatic setup(input logic [15:0] ph, input logic [15:0] sph, input logic [15:0] tc, input logic [15:0] ctl);
		wr(OFF_CTRL, 16'h0000, r);
		wr(OFF_PHASE, ph, r);
		wr(OFF_SPHASE, sph, r);
		wr(OFF_TRGCON, tc, r);
		wr(OFF_CTRL, ctl, r);
		repeat (64) @(posedge aclk);
	endtask

	// 640 cycles spans whole periods of 32, 40 and 64, so tallies are exact
	task automatic meas(input int hp, input int lp, input int lsd, input int paired, input int t1, input int t2);
		int s[7];
		s = '{hs_on, ls_on, hs_up, ls_up, trg, trg2, same};
		repeat (640) @(posedge aclk);
		chk("high-side on time", 12 * (640 / hp), hs_on - s[0]);
		chk("high-side pulses", 640 / hp, hs_up - s[2]);
		if (paired != 0) begin
			chk("legs equal cycles", 0, same - s[6]);
		end else begin
			chk("low-side on time", lsd * (640 / lp), ls_on - s[1]);
			chk("low-side pulses", 640 / lp, ls_up - s[3]);
		end
		chk("primary triggers", t1, trg - s[4]);
		chk("secondary triggers", t2, trg2 - s[5]);
	endtask

	// Enable from stopped with trigger setup tc, count edges to the first trigger
	task automatic first_trg(input logic [15:0] tc, output int n);
		wr(OFF_CTRL, 16'h0000, r);
		wr(OFF_TRGCON, tc, r);
		wr(OFF_CTRL, 16'h0001, r);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (trg_o !== 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), d, r);
			chk("reset value", 32'h0, d);
		end
		for (int i = 0; i < 6; i++) begin
			v = lfsr_q;
			wr(8'(4 * i), v, r);
			mdl[i] = int'(v & msk[i]);
			chk("write response", 32'(RESP_OKAY), 32'(r));
		end
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), d, r);
			chk("register readback", 32'(mdl[i]), d);
		end
		wr(8'h3c, 16'h1234, r);
		chk("unmapped write response", 32'(RESP_SLVERR), 32'(r));
		rd(8'h3c, d, r);
		chk("unmapped read response", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped read data", 32'h0, d);
		wr(OFF_CTRL, 16'h0004, r);
		repeat (2) @(posedge aclk);
		chk("alternate dead time", 32'(mdl[4]), 32'(adt));
		wr(OFF_CTRL, 16'h0000, r);
		repeat (2) @(posedge aclk);
		chk("dead time", 32'(mdl[3]), 32'(adt));
		// Duties sit inside 8 .. period-8 for every period used below
		wr(OFF_MPER, 16'h0027, r);
		wr(OFF_PDC, 16'h000c, r);
		wr(OFF_SDC, 16'h0014, r);
		for (int pm = 0; pm < 3; pm++) begin
			setup(16'h0005, 16'h1234, 16'h0000, 16'((pm << 4) | 1));
			meas(40, 40, 0, 1, 16, 0);
		end
		setup(16'h0005, 16'h0009, 16'h0000, 16'h0031);
		meas(40, 40, 20, 0, 16, 16);
		// Each leg shifted on its own: low rises the phase difference after high
		do @(posedge aclk); while (hs !== 1'b0);
		do @(posedge aclk); while (hs !== 1'b1);
		g = 0;
		while (ls !== 1'b1) begin
			@(posedge aclk);
			g++;
		end
		chk("low-side lag behind high side", 32'(16'h0009 - 16'h0005), 32'(g));
		setup(16'h0005, 16'h0009, 16'h0080, 16'h0031);
		meas(40, 40, 20, 0, 32, 0);
		setup(16'h001f, 16'h1234, 16'h0000, 16'h0003);
		meas(32, 32, 0, 1, 20, 0);
		setup(16'h001f, 16'h003f, 16'h0000, 16'h0033);
		meas(32, 64, 20, 0, 20, 10);
		foreach (codes[k]) begin
			setup(16'h0000, 16'h0000, 16'(codes[k] << 12), 16'h0001);
			do @(posedge aclk); while (trg_o !== 1'b1);
			repeat (2) begin
				g = 0;
				do begin
					@(posedge aclk);
					g++;
				end while (trg_o !== 1'b1);
			end
			chk("trigger spacing", 32'((codes[k] + 1) * 40), 32'(g));
		end
		// Start field holds off the first trigger by whole PWM cycles; odd so never zero
		first_trg(16'h0000, g0);
		v = 16'({lfsr_q[4:0], 1'b1});
		first_trg(v, g);
		chk("first trigger delay", 32'(int'(v) * 40), 32'(g - g0));
		// Reset in mid-run: outputs and registers return to their cleared state
		wr(OFF_CTRL, 16'h0031, r);
		repeat (50) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("high side after reset", 32'h0, 32'(hs));
		chk("low side after reset", 32'h0, 32'(ls));
		rd(OFF_CTRL, d, r);
		chk("control after reset", 32'h0, d);
		rd(OFF_TRGCON, d, r);
		chk("trigger control after reset", 32'h0, d);
		end_sim;
	end

	// Watchdog well beyond the expected run of about 9200 cycles
	initial begin
		repeat (40000) @(posedge aclk);
		err_total++;
		$display("[FAIL] run length expected finish seen timeout");
		end_sim;
	end
endmodule
`default_nettype wire
